// file: include/rdr_pkg.sv
// constants for the reader interrupt, timer and power block
// assumes a 100 MHz bus clock and APB word-aligned byte addresses
package rdr_pkg;
  // bus clock
  localparam int unsigned CLK_PERIOD_NS = 10;
  // register byte addresses
  localparam logic [7:0] A_CONTROL = 8'h00;
  localparam logic [7:0] A_COMMON_EN = 8'h04;
  localparam logic [7:0] A_SECOND_EN = 8'h08;
  localparam logic [7:0] A_COMMON_FLAG = 8'h0c;
  localparam logic [7:0] A_SECOND_FLAG = 8'h10;
  localparam logic [7:0] A_PRIMARY_STATUS = 8'h14;
  localparam logic [7:0] A_TIMER_CONFIG = 8'h18;
  localparam logic [7:0] A_DIVIDER_LOWER = 8'h1c;
  localparam logic [7:0] A_RELOAD_HIGH = 8'h20;
  localparam logic [7:0] A_RELOAD_LOW = 8'h24;
  localparam logic [7:0] A_COUNT_NOW_HIGH = 8'h28;
  localparam logic [7:0] A_COUNT_NOW_LOW = 8'h2c;
  localparam logic [7:0] A_FIFO_THRESHOLD = 8'h30;
  localparam logic [7:0] A_ANTENNA_DRIVE = 8'h34;
  localparam logic [7:0] A_DETECT_CONFIG = 8'h38;
  localparam logic [7:0] A_SLEEP_LENGTH = 8'h3c;
  localparam logic [7:0] A_DETECT_LENGTH = 8'h40;
  // control register bits
  localparam int unsigned CTL_GO = 0;
  localparam int unsigned CTL_HALT = 1;
  localparam int unsigned CTL_SLEEP = 2;
  localparam int unsigned CTL_DETECT = 3;
  // common flag bits; bit 7 of a flag write selects set (1) or clear (0)
  localparam int unsigned F_TIMER = 0;
  localparam int unsigned F_FAULT = 1;
  localparam int unsigned F_EMPTY = 2;
  localparam int unsigned F_FULL = 3;
  localparam int unsigned F_CMD = 4;
  localparam int unsigned F_RX = 5;
  localparam int unsigned F_TX = 6;
  localparam int unsigned F_SETMODE = 7;
  // secondary flag bits
  localparam int unsigned S_CRC = 0;
  localparam int unsigned S_CARD = 1;
  // timer config bits (divider upper bits sit in [3:0])
  localparam int unsigned TC_AUTO = 4;
  localparam int unsigned TC_RELOAD = 5;
  // reset values and fifo depth
  localparam logic [5:0] RST_THRESHOLD = 6'h08;
  localparam logic [1:0] RST_RF = 2'h0;
  localparam logic [3:0] IDLE_CMD = 4'h0;
  localparam logic [6:0] FIFO_DEPTH = 7'h40;
  // timing
  localparam int unsigned T_WAKE_NS = 400000;
  localparam int unsigned WAKE_EXIT_CYC = 1024;
  localparam int unsigned SLEEP_SHIFT = 8;  // sleep unit of 256 slow ticks
  localparam int unsigned DETECT_SHIFT = 6; // detect unit of 16 x 4 edges
  typedef enum logic [1:0] {LP_OFF, LP_SLEEP, LP_WAKE, LP_DETECT} low_power_card_detect_t;
endpackage : rdr_pkg

// file: src/reader_irq_timer_power.sv
// interrupt flags, 16-bit timer, card-detect sequencer and power-down
// control for a contactless reader; registers over APB, event sources and
// fifo/error status come from logic on pclk, three pins are asynchronous
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/100ps
module reader_irq_timer_power
  import rdr_pkg::*;
#(
  parameter int unsigned WAKE_CYC = T_WAKE_NS / CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // event sources on pclk
  input wire logic tx_frame_end,
  input wire logic rx_stream_end,
  input wire logic crc_ready,
  input wire logic [3:0] command_field,
  input wire logic [6:0] fifo_length,
  input wire logic [7:0] error_status,
  input wire logic protocol_start,
  input wire logic [7:0] field_level,
  // asynchronous pins
  input wire logic reset_sleep_pin,
  input wire logic xtal_27m,
  input wire logic clk_32k,
  // outputs
  output logic host_interrupt_pin,
  output logic tx1_drive_en,
  output logic tx2_drive_en,
  output logic osc_enable,
  output logic reader_mode
);

  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic [2:0] pd_sync;
    logic [2:0] xt_sync;
    logic [2:0] sk_sync;
    logic half;
    logic [6:0] cflag;
    logic [6:0] cen;
    logic [1:0] sflag;
    logic [1:0] sen;
    logic [3:0] div_hi;
    logic [7:0] div_lo;
    logic autostart;
    logic reload_mode;
    logic [15:0] reload;
    logic [15:0] count;
    logic [12:0] pre;
    logic run;
    logic [5:0] water;
    logic [1:0] rf;
    logic [3:0] delta;
    logic [2:0] skip;
    logic [7:0] sleep_len;
    logic [3:0] det_len;
    logic sleep_req;
    logic waking;
    logic [10:0] wake_cnt;
    logic lp_en;
    low_power_card_detect_t lp_st;
    logic [16:0] lp_cnt;
    logic [2:0] lp_rep;
    logic [7:0] base;
    logic base_ok;
    logic [3:0] prev_cmd;
    logic prev_full;
    logic prev_empty;
    logic crc_rdy;
    logic irq;
    logic tx1;
    logic tx2;
    logic osc;
    logic reader;
  } state_t;

  localparam state_t RST = '{
    lp_st: LP_OFF, water: RST_THRESHOLD, rf: RST_RF, prev_cmd: IDLE_CMD,
    pd_sync: 3'h7, default: '0};

  state_t st_ff;
  state_t nxt_st;

  // flag register update; hardware set is applied last so it wins
  function automatic logic [6:0] flag_next(input logic [6:0] cur,
      input logic [6:0] hw_set, input logic wr, input logic [7:0] wd);
    logic [6:0] v;
    v = cur;
    if (wr) begin
      v = wd[F_SETMODE] ? (cur | wd[6:0]) : (cur & ~wd[6:0]);
    end
    return v | hw_set;
  endfunction : flag_next

  logic hw_pd;
  logic xt_edge;
  logic tick;
  logic slow_tick;
  logic acc;
  logic wr;
  logic full_bit;
  logic empty_bit;
  logic [6:0] c_set;
  logic [6:0] s_set;
  logic [12:0] pre_top;
  logic [7:0] diff;
  logic start;
  logic stop;

  // pin-derived strobes read only the second and third sync stages
  assign hw_pd = ~st_ff.pd_sync[1];
  assign xt_edge = st_ff.xt_sync[1] & ~st_ff.xt_sync[2] & st_ff.osc;
  assign tick = xt_edge & st_ff.half;
  assign slow_tick = st_ff.sk_sync[1] & ~st_ff.sk_sync[2];
  assign acc = psel & penable & st_ff.ready;
  assign wr = acc & pwrite & ~hw_pd;
  assign pre_top = {st_ff.div_hi, st_ff.div_lo, 1'b0};
  assign full_bit = (FIFO_DEPTH - fifo_length) <= {1'b0, st_ff.water};
  assign empty_bit = fifo_length <= {1'b0, st_ff.water};
  assign diff = (field_level >= st_ff.base) ? field_level - st_ff.base
                                            : st_ff.base - field_level;
  assign start = (wr && paddr == A_CONTROL && pwdata[CTL_GO])
                 || (protocol_start && st_ff.autostart && !hw_pd);
  assign stop = wr && paddr == A_CONTROL && pwdata[CTL_HALT];

  // hardware flag sources, blocked while the pin holds power-down
  always_comb begin
    c_set = '0;
    s_set = '0;
    if (!hw_pd) begin
      c_set[F_TX] = tx_frame_end;
      c_set[F_RX] = rx_stream_end;
      c_set[F_CMD] = command_field == IDLE_CMD
                     && st_ff.prev_cmd != IDLE_CMD;
      c_set[F_FULL] = full_bit & ~st_ff.prev_full;
      c_set[F_EMPTY] = empty_bit & ~st_ff.prev_empty;
      c_set[F_FAULT] = |error_status;
      s_set[S_CRC] = crc_ready & ~st_ff.crc_rdy;
      // a restart on the same tick reloads, so no 1-to-0 step happens
      c_set[F_TIMER] = st_ff.run && tick && st_ff.pre == '0
                       && st_ff.count == 16'h0001 && !stop
                       && !start;
      s_set[S_CARD] = st_ff.lp_st == LP_DETECT && st_ff.base_ok
                      && xt_edge && st_ff.lp_en
                      && st_ff.lp_cnt >= {7'h0, st_ff.det_len, 6'h00}
                      && diff > {4'h0, st_ff.delta};
    end
  end

  // next-state logic for the whole block
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pd_sync = {st_ff.pd_sync[1:0], reset_sleep_pin};
    nxt_st.xt_sync = {st_ff.xt_sync[1:0], xtal_27m};
    nxt_st.sk_sync = {st_ff.sk_sync[1:0], clk_32k};
    if (xt_edge) begin
      nxt_st.half = ~st_ff.half;
    end

    // apb: ready is raised for the access phase after each setup cycle
    nxt_st.ready = psel & ~penable;
    nxt_st.slverr = 1'b0;
    if (psel && !penable) begin
      nxt_st.rdata = '0;
      nxt_st.slverr = hw_pd;
      unique case (paddr)
        A_CONTROL: nxt_st.rdata[CTL_DETECT:CTL_SLEEP] =
          {st_ff.lp_en, st_ff.sleep_req};
        A_COMMON_EN: nxt_st.rdata[6:0] = st_ff.cen;
        A_SECOND_EN: nxt_st.rdata[1:0] = st_ff.sen;
        A_COMMON_FLAG: nxt_st.rdata[6:0] = st_ff.cflag;
        A_SECOND_FLAG: nxt_st.rdata[1:0] = st_ff.sflag;
        A_PRIMARY_STATUS: nxt_st.rdata[5:0] = {st_ff.sleep_req,
          st_ff.crc_rdy, st_ff.irq, st_ff.run, st_ff.prev_full,
          st_ff.prev_empty};
        A_TIMER_CONFIG: nxt_st.rdata[5:0] = {st_ff.reload_mode,
          st_ff.autostart, st_ff.div_hi};
        A_DIVIDER_LOWER: nxt_st.rdata[7:0] = st_ff.div_lo;
        A_RELOAD_HIGH: nxt_st.rdata[7:0] = st_ff.reload[15:8];
        A_RELOAD_LOW: nxt_st.rdata[7:0] = st_ff.reload[7:0];
        A_COUNT_NOW_HIGH: nxt_st.rdata[7:0] = st_ff.count[15:8];
        A_COUNT_NOW_LOW: nxt_st.rdata[7:0] = st_ff.count[7:0];
        A_FIFO_THRESHOLD: nxt_st.rdata[5:0] = st_ff.water;
        A_ANTENNA_DRIVE: nxt_st.rdata[1:0] = st_ff.rf;
        A_DETECT_CONFIG: nxt_st.rdata[6:0] = {st_ff.skip, st_ff.delta};
        A_SLEEP_LENGTH: nxt_st.rdata[7:0] = st_ff.sleep_len;
        A_DETECT_LENGTH: nxt_st.rdata[3:0] = st_ff.det_len;
        default: nxt_st.slverr = 1'b1;
      endcase
    end

    // register writes; go and halt are strobes and are not stored
    if (wr) begin
      unique case (paddr)
        A_CONTROL: begin
          if (pwdata[CTL_SLEEP]) begin
            nxt_st.sleep_req = 1'b1;
            nxt_st.waking = 1'b0;
          end else if (st_ff.sleep_req) begin
            nxt_st.waking = 1'b1;
          end
          nxt_st.lp_en = pwdata[CTL_DETECT];
          if (pwdata[CTL_DETECT]) begin
            nxt_st.reader = 1'b0;
          end
        end
        A_COMMON_EN: nxt_st.cen = pwdata[6:0];
        A_SECOND_EN: nxt_st.sen = pwdata[1:0];
        A_TIMER_CONFIG: begin
          nxt_st.div_hi = pwdata[3:0];
          nxt_st.autostart = pwdata[TC_AUTO];
          nxt_st.reload_mode = pwdata[TC_RELOAD];
        end
        A_DIVIDER_LOWER: nxt_st.div_lo = pwdata[7:0];
        A_RELOAD_HIGH: nxt_st.reload[15:8] = pwdata[7:0];
        A_RELOAD_LOW: nxt_st.reload[7:0] = pwdata[7:0];
        A_FIFO_THRESHOLD: nxt_st.water = pwdata[5:0];
        A_ANTENNA_DRIVE: nxt_st.rf = pwdata[1:0];
        A_DETECT_CONFIG: begin
          nxt_st.delta = pwdata[3:0];
          nxt_st.skip = pwdata[6:4];
        end
        A_SLEEP_LENGTH: nxt_st.sleep_len = pwdata[7:0];
        A_DETECT_LENGTH: nxt_st.det_len = pwdata[3:0];
        default: ;
      endcase
    end

    // sticky flags; host may set or clear, hardware set wins
    nxt_st.cflag = flag_next(st_ff.cflag, c_set,
      wr && paddr == A_COMMON_FLAG, pwdata[7:0]);
    nxt_st.sflag = 2'(flag_next({5'h0, st_ff.sflag}, s_set,
      wr && paddr == A_SECOND_FLAG, pwdata[7:0]));
    if (!hw_pd) begin
      nxt_st.prev_cmd = command_field;
      nxt_st.prev_full = full_bit;
      nxt_st.prev_empty = empty_bit;
      nxt_st.crc_rdy = crc_ready;
    end

    // wake-up delay after the sleep bit is written low
    if (st_ff.waking && !hw_pd) begin
      nxt_st.wake_cnt = st_ff.wake_cnt + 11'h001;
      if (st_ff.wake_cnt == 11'(WAKE_EXIT_CYC - 1)) begin
        nxt_st.sleep_req = 1'b0;
        nxt_st.waking = 1'b0;
      end
    end
    if (!nxt_st.waking) begin
      nxt_st.wake_cnt = '0;
    end

    // timer: prescaler of 2p+1 ticks feeding a down counter
    if (stop) begin
      nxt_st.run = 1'b0;
    end else if (start) begin
      nxt_st.run = 1'b1;
      nxt_st.count = st_ff.reload;
      nxt_st.pre = pre_top;
    end else if (st_ff.run && tick) begin
      if (st_ff.pre == '0) begin
        nxt_st.pre = pre_top;
        if (st_ff.count == '0) begin
          if (st_ff.reload_mode) begin
            nxt_st.count = st_ff.reload;
          end else begin
            nxt_st.run = 1'b0;
          end
        end else begin
          nxt_st.count = st_ff.count - 16'h0001;
        end
      end else begin
        nxt_st.pre = st_ff.pre - 13'h0001;
      end
    end

    // card detection sequencer: sleep, wake settle, detect x (skip+1)
    unique case (st_ff.lp_st)
      LP_OFF: begin
        nxt_st.lp_cnt = '0;
        nxt_st.lp_rep = '0;
        if (st_ff.lp_en && !hw_pd) begin
          nxt_st.lp_st = LP_SLEEP;
        end
      end
      LP_SLEEP: begin
        if (st_ff.lp_cnt >= {1'b0, st_ff.sleep_len, 8'h00}) begin
          nxt_st.lp_st = LP_WAKE;
          nxt_st.lp_cnt = '0;
        end else if (slow_tick) begin
          nxt_st.lp_cnt = st_ff.lp_cnt + 17'h00001;
        end
      end
      LP_WAKE: begin
        nxt_st.lp_cnt = st_ff.lp_cnt + 17'h00001;
        if (st_ff.lp_cnt >= 17'(WAKE_CYC - 1)) begin
          nxt_st.lp_st = LP_DETECT;
          nxt_st.lp_cnt = '0;
        end
      end
      LP_DETECT: begin
        if (xt_edge) begin
          nxt_st.lp_cnt = st_ff.lp_cnt + 17'h00001;
          if (st_ff.lp_cnt >= {7'h0, st_ff.det_len, 6'h00}) begin
            nxt_st.lp_cnt = '0;
            nxt_st.base = st_ff.base_ok ? st_ff.base : field_level;
            nxt_st.base_ok = 1'b1;
            if (s_set[S_CARD]) begin
              nxt_st.lp_en = 1'b0;
              nxt_st.reader = 1'b1;
              nxt_st.lp_st = LP_OFF;
            end else if (st_ff.lp_rep == st_ff.skip) begin
              nxt_st.lp_rep = '0;
              nxt_st.lp_st = LP_SLEEP;
            end else begin
              nxt_st.lp_rep = st_ff.lp_rep + 3'h1;
            end
          end
        end
      end
    endcase
    // dropping the enable abandons the sequence and the baseline
    if (!nxt_st.lp_en) begin
      nxt_st.lp_st = LP_OFF;
      nxt_st.base_ok = 1'b0;
    end

    // outputs computed from next state so each pin is a flop
    nxt_st.irq = |(nxt_st.cflag & nxt_st.cen)
                 || |(nxt_st.sflag & nxt_st.sen);
    nxt_st.osc = ~nxt_st.sleep_req & st_ff.pd_sync[1];
    nxt_st.tx1 = nxt_st.rf[0] & nxt_st.osc;
    nxt_st.tx2 = nxt_st.rf[1] & nxt_st.osc;
  end

  // single state register; reset takes constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.rdata;
  assign pready = st_ff.ready;
  assign pslverr = st_ff.slverr;
  assign host_interrupt_pin = st_ff.irq;
  assign tx1_drive_en = st_ff.tx1;
  assign tx2_drive_en = st_ff.tx2;
  assign osc_enable = st_ff.osc;
  assign reader_mode = st_ff.reader;

  // checks on the design's own behaviour
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_irq_pin_pending: assert property (
    host_interrupt_pin == (|(st_ff.cflag & st_ff.cen)
                           || |(st_ff.sflag & st_ff.sen)))
    else $error("interrupt pin disagrees with enabled flags");
  chk_timer_flag_set: assert property (
    c_set[F_TIMER] |=> st_ff.cflag[F_TIMER] && st_ff.count == 16'h0000)
    else $error("timer flag not set on count one to zero");
  chk_timer_reload: assert property (
    st_ff.run && tick && st_ff.pre == '0 && st_ff.count == '0
    && st_ff.reload_mode && !stop && !start
    |=> st_ff.run && st_ff.count == $past(st_ff.reload))
    else $error("timer did not reload at zero");
  chk_timer_stops: assert property (
    st_ff.run && tick && st_ff.pre == '0 && st_ff.count == '0
    && !st_ff.reload_mode && !start |=> !st_ff.run)
    else $error("one-shot timer kept running");
  chk_halt_strobe: assert property (
    stop |=> !st_ff.run)
    else $error("halt strobe did not stop the timer");
  chk_prescale_load: assert property (
    st_ff.run && tick && st_ff.pre == '0 && !start && !stop
    |=> st_ff.pre == $past(pre_top))
    else $error("prescaler not reloaded with twice divider");
  chk_fault_flag: assert property (
    (|error_status) && !hw_pd |=> st_ff.cflag[F_FAULT])
    else $error("error bit did not set fault flag");
  chk_sleep_enter: assert property (
    wr && paddr == A_CONTROL && pwdata[CTL_SLEEP]
    |=> st_ff.sleep_req && !osc_enable && !tx1_drive_en)
    else $error("sleep request did not stop oscillator");
  chk_wake_time: assert property (
    $fell(st_ff.sleep_req) |-> $past(st_ff.waking)
    && $past(st_ff.wake_cnt) == 11'(WAKE_EXIT_CYC - 1))
    else $error("sleep bit cleared before the full wake count");
  chk_rf_off: assert property (
    st_ff.rf == 2'h0 |-> !tx1_drive_en && !tx2_drive_en)
    else $error("drivers on with drive field zero");

endmodule : reader_irq_timer_power

// file: dv/osc_model.sv
// crystal and slow clock sources that sit outside the reader block
// assumes the power-down pin stops the crystal, slow clock runs free
`timescale 1ns/100ps
module osc_model #(
  parameter real XT_HALF = 18.4,
  parameter real SLOW_HALF = 100.0
) (
  // power-down pin, low stops the crystal
  input wire logic reset_sleep_pin,
  // clock outputs
  output logic xtal_27m,
  output logic clk_32k
);
  // 27.12 MHz crystal, still while the pin holds power-down
  initial begin
    xtal_27m = 1'b0;
    forever begin
      #XT_HALF;
      if (reset_sleep_pin) xtal_27m = ~xtal_27m;
    end
  end
  // slow clock sped up so one sleep phase fits a short run
  initial begin
    clk_32k = 1'b0;
    forever #SLOW_HALF clk_32k = ~clk_32k;
  end
endmodule : osc_model

// file: dv/testbench.sv
// self-checking bench for the reader interrupt, timer and power block
// assumes one APB access cycle and a crystal model on the far side
`timescale 1ns/100ps
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
  mismatches++; $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
  end end
module testbench;
  import rdr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, error_status, field_level;
  logic [31:0] pwdata, prdata, rd, exp_flags;
  logic tx_frame_end, rx_stream_end, crc_ready, protocol_start;
  logic [3:0] command_field;
  logic [6:0] fifo_length;
  logic reset_sleep_pin, xtal_27m, clk_32k, host_interrupt_pin;
  logic tx1_drive_en, tx2_drive_en, osc_enable, reader_mode;
  logic [15:0] seed;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  int n, t0;
  int fbit[6] = '{F_TX, F_RX, F_FAULT, F_CMD, F_EMPTY, F_FULL};
  // timer model, P=2 R=4, ticks of 73.6 ns: the flag comes after R periods
  // of 2P+1 ticks, and in reload mode every R+1 periods after that
  int exp_first = (2 * 2 + 1) * 4 * 736 / 100;
  int exp_cyc = (2 * 2 + 1) * (4 + 1) * 736 / 100;
  int e_lo, e_hi;

  reader_irq_timer_power #(.WAKE_CYC(20)) u_dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .tx_frame_end, .rx_stream_end, .crc_ready,
    .command_field, .fifo_length, .error_status, .protocol_start,
    .field_level, .reset_sleep_pin, .xtal_27m, .clk_32k,
    .host_interrupt_pin, .tx1_drive_en, .tx2_drive_en, .osc_enable,
    .reader_mode);
  osc_model u_osc (.reset_sleep_pin, .xtal_27m, .clk_32k);

  // clock, and a cycle ceiling that cuts a hang short
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      print_verdict();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask : tick

  // one APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHECK(rd, e)
  endtask : chk_rd

  // bounded wait on the interrupt pin, cycles left in n
  task automatic wait_pin(input int lim);
    n = 0;
    while (host_interrupt_pin !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
  endtask : wait_pin

  initial begin
    {presetn, psel, penable, pwrite, tx_frame_end, rx_stream_end} = '0;
    {crc_ready, protocol_start, command_field, error_status} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    field_level = 8'h40;
    fifo_length = 7'h20;
    reset_sleep_pin = 1'b1;
    seed = 16'd10946;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, unmapped address, random reload and divider
    chk_rd(A_FIFO_THRESHOLD, {26'h0, RST_THRESHOLD});
    chk_rd(A_ANTENNA_DRIVE, {30'h0, RST_RF});
    apb(1'b0, 8'hfc, 32'h0);
    `CHECK({err, rd}, {1'b1, 32'h0})
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      apb(1'b1, A_RELOAD_LOW, {24'h0, seed[7:0]});
      apb(1'b1, A_DIVIDER_LOWER, {24'h0, seed[15:8]});
      chk_rd(A_RELOAD_LOW, {24'h0, seed[7:0]});
      chk_rd(A_DIVIDER_LOWER, {24'h0, seed[15:8]});
      apb(1'b1, A_TIMER_CONFIG, {26'h0, seed[13:8]});
      chk_rd(A_TIMER_CONFIG, {26'h0, seed[13:8]});
    end
    // host set and clear of the timer flag, enable-gated pin
    apb(1'b1, A_COMMON_EN, 32'h7f);
    apb(1'b1, A_COMMON_FLAG, 32'h81);
    tick(2);
    `CHECK(host_interrupt_pin, 1'b1)
    chk_rd(A_PRIMARY_STATUS, 32'h08);
    apb(1'b1, A_COMMON_FLAG, 32'h01);
    tick(2);
    `CHECK(host_interrupt_pin, 1'b0)
    // each hardware event sets its own flag, model accumulates them
    exp_flags = '0;
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      case (i)
        0: tx_frame_end <= 1'b1;
        1: rx_stream_end <= 1'b1;
        2: error_status <= 8'h10;
        3: command_field <= 4'h5;
        4: fifo_length <= 7'h05;
        default: fifo_length <= 7'h3c;
      endcase
      @(posedge pclk);
      {tx_frame_end, rx_stream_end, error_status} <= '0;
      command_field <= IDLE_CMD;
      tick(3);
      exp_flags[fbit[i]] = 1'b1;
      chk_rd(A_COMMON_FLAG, exp_flags);
    end
    chk_rd(A_PRIMARY_STATUS, 32'h0a);
    `CHECK(host_interrupt_pin, 1'b1)
    fifo_length <= 7'h20;
    crc_ready <= 1'b1;
    tick(3);
    chk_rd(A_SECOND_FLAG, 32'h1);
    chk_rd(A_PRIMARY_STATUS, 32'h18);
    crc_ready <= 1'b0;
    apb(1'b1, A_COMMON_FLAG, 32'h7f);
    apb(1'b1, A_SECOND_FLAG, 32'h03);
    tick(2);
    `CHECK(host_interrupt_pin, 1'b0)
    // timer in stop mode, then reload mode over two periods
    apb(1'b1, A_DIVIDER_LOWER, 32'h2);
    apb(1'b1, A_RELOAD_HIGH, 32'h0);
    apb(1'b1, A_RELOAD_LOW, 32'h4);
    apb(1'b1, A_COMMON_EN, 32'h01);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, A_TIMER_CONFIG, m ? 32'h20 : 32'h0);
      apb(1'b1, A_CONTROL, 32'h1);
      t0 = cyc;
      for (int k = 0; k <= m; k++) begin
        wait_pin(400);
        n = cyc - t0;
        t0 = cyc;
        // first flag from go has a loose start phase, the repeat is held to two cycles
        e_lo = k ? exp_cyc - 2 : exp_first - 12;
        e_hi = k ? exp_cyc + 2 : exp_first + 12;
        `CHECK(n >= e_lo && n <= e_hi, 1'b1)
        apb(1'b1, A_COMMON_FLAG, 32'h01);
        tick(2);
      end
      // one-shot stops one period after the flag; reload keeps running
      tick(60);
      if (m == 0) chk_rd(A_COUNT_NOW_LOW, 32'h0);
      chk_rd(A_PRIMARY_STATUS, m ? 32'h4 : 32'h0);
    end
    apb(1'b1, A_CONTROL, 32'h2);
    tick(2);
    chk_rd(A_PRIMARY_STATUS, 32'h0);
    // autostart from a protocol event
    apb(1'b1, A_TIMER_CONFIG, 32'h10);
    @(posedge pclk);
    protocol_start <= 1'b1;
    @(posedge pclk);
    protocol_start <= 1'b0;
    tick(3);
    chk_rd(A_PRIMARY_STATUS, 32'h4);
    apb(1'b1, A_CONTROL, 32'h2);
    // antenna drivers on and off
    apb(1'b1, A_ANTENNA_DRIVE, 32'h3);
    tick(2);
    `CHECK({tx1_drive_en, tx2_drive_en}, 2'b11)
    apb(1'b1, A_ANTENNA_DRIVE, 32'h0);
    tick(2);
    `CHECK({tx1_drive_en, tx2_drive_en}, 2'b00)
    // software sleep keeps registers, wake takes 1024 clocks
    apb(1'b1, A_FIFO_THRESHOLD, 32'h11);
    apb(1'b1, A_CONTROL, 32'h4);
    tick(1);
    `CHECK(osc_enable, 1'b0)
    chk_rd(A_FIFO_THRESHOLD, 32'h11);
    apb(1'b1, A_CONTROL, 32'h0);
    t0 = cyc;
    do apb(1'b0, A_CONTROL, 32'h0);
    while (rd[CTL_SLEEP] === 1'b1 && cyc - t0 < 1500);
    `CHECK(cyc - t0 >= 1020 && cyc - t0 <= 1032, 1'b1)
    // pin power-down refuses writes and stops the oscillator
    reset_sleep_pin <= 1'b0;
    tick(4);
    `CHECK(osc_enable, 1'b0)
    apb(1'b1, A_FIFO_THRESHOLD, 32'h22);
    `CHECK(err, 1'b1)
    reset_sleep_pin <= 1'b1;
    tick(4);
    chk_rd(A_FIFO_THRESHOLD, 32'h11);
    // card detect: baseline first, later change beyond delta found
    apb(1'b1, A_SLEEP_LENGTH, 32'h1);
    apb(1'b1, A_DETECT_LENGTH, 32'h1);
    apb(1'b1, A_DETECT_CONFIG, 32'h04);
    apb(1'b1, A_SECOND_EN, 32'h02);
    apb(1'b1, A_CONTROL, 32'h8);
    tick(6500);
    `CHECK(host_interrupt_pin, 1'b0)
    field_level <= 8'h60;
    wait_pin(12000);
    `CHECK(n >= 2560, 1'b1)
    `CHECK(reader_mode, 1'b1)
    chk_rd(A_SECOND_FLAG, 32'h2);
    chk_rd(A_CONTROL, 32'h0);
    print_verdict();
  end
endmodule : testbench
